// ==== src/tes_pkg.sv ====
/*
 Constants and types for the transmit envelope and symbol encoder.
 Assumes a 100 MHz mclk and byte-wide registers on a plain address port.
*/
package tes_pkg;
   // ****************************************
   // Register offsets, fields, reset values
   // ****************************************
   localparam logic [7:0] OFS_MOD = 8'h4b;
   localparam logic [7:0] OFS_FREQ = 8'h4c;
   localparam logic [7:0] OFS_S0H = 8'h4d;
   localparam logic [7:0] OFS_S0L = 8'h4e;
   localparam logic [7:0] OFS_S1H = 8'h4f;
   localparam logic [7:0] OFS_S1L = 8'h50;
   localparam logic [7:0] OFS_S2 = 8'h51;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam int MOD_FSTEP = 7;
   localparam int MOD_MILLER = 6;
   localparam int MOD_PULSE = 4;
   localparam int MOD_INV = 3;
   localparam int MOD_ENV = 0;
   localparam int FRQ_HI_SC = 7;
   localparam int FRQ_HI_BR = 4;
   localparam int FRQ_LO_SC = 3;
   localparam int FRQ_LO_BR = 0;
   // ****************************************
   // Codes
   // ****************************************
   localparam logic [1:0] PULSE_NONE = 2'h0;
   localparam logic [1:0] PULSE_START = 2'h1;
   localparam logic [1:0] PULSE_HALF = 2'h2;
   localparam logic [1:0] PULSE_Q3 = 2'h3;
   localparam logic [2:0] ENV_DIRECT = 3'h0;
   localparam logic [2:0] ENV_MANCH = 3'h1;
   localparam logic [2:0] ENV_MANCH_SC = 3'h2;
   localparam logic [2:0] ENV_BPSK = 3'h3;
   localparam logic [2:0] ENV_RZ_LATE = 3'h4;
   localparam logic [2:0] ENV_RZ_EARLY = 3'h5;
   localparam logic [2:0] RATE_26K = 3'h2;
   localparam logic [2:0] RATE_53K = 3'h3;
   localparam logic [2:0] RATE_106K = 3'h4;
   localparam logic [2:0] RATE_212K = 3'h5;
   localparam logic [2:0] RATE_424K = 3'h6;
   localparam logic [2:0] RATE_848K = 3'h7;
   localparam logic [3:0] BYTE_TOP = 4'h7;
   localparam logic [3:0] SYM2_TOP = 4'h7;
   // ****************************************
   // Timing, frequencies in kHz
   // ****************************************
   localparam int CLK_KHZ = 100000;
   localparam int F26 = 26;
   localparam int F53 = 53;
   localparam int F106 = 106;
   localparam int F212 = 212;
   localparam int F424 = 424;
   localparam int F848 = 848;
   localparam logic [11:0] CYC_26K = 12'(CLK_KHZ / F26);
   localparam logic [11:0] CYC_53K = 12'(CLK_KHZ / F53);
   localparam logic [11:0] CYC_106K = 12'(CLK_KHZ / F106);
   localparam logic [11:0] CYC_212K = 12'(CLK_KHZ / F212);
   localparam logic [11:0] CYC_424K = 12'(CLK_KHZ / F424);
   localparam logic [11:0] CYC_848K = 12'(CLK_KHZ / F848);
   localparam logic [11:0] CYC_SC424 = 12'(CLK_KHZ / (2 * F424));
   localparam logic [11:0] CYC_SC848 = 12'(CLK_KHZ / (2 * F848));
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SOF = 5'h02,
      ST_DATA = 5'h04,
      ST_EOF = 5'h08,
      ST_GAP = 5'h10
   } tes_state_t;
   typedef struct packed {
      logic [7:0] modCtrl;
      logic [7:0] symFreq;
      logic [7:0] symZeroUpperByte;
      logic [7:0] symZeroLowerByte;
      logic [7:0] symOneUpperByte;
      logic [7:0] symOneLowerByte;
      logic [7:0] symTwoPatternByte;
   } tes_regs_t;
   typedef struct packed {
      logic frameStep;
      logic dataMillerEnable;
      logic [1:0] dataPulseSelect;
      logic dataEnvelopeInvert;
      logic [2:0] dataEnvelopeSelect;
      logic symHiPairSubcarrierSel;
      logic [2:0] symHiPairBitrateSel;
      logic symLoPairSubcarrierSel;
      logic [2:0] symLoPairBitrateSel;
      logic [15:0] sym0;
      logic [15:0] sym1;
      logic [7:0] sym2;
      logic [3:0] symZeroLen;
      logic [3:0] symOneLen;
   } tes_cfg_t;
   typedef struct packed {
      tes_state_t state;
      tes_regs_t regs;
      tes_cfg_t cfg;
      logic [7:0] shift;
      logic [3:0] bitIdx;
      logic [11:0] cyc;
      logic prevBit;
      logic [11:0] sc;
      logic scPh;
      logic env;
      logic active;
      logic [7:0] rdData;
   } tes_st_t;
endpackage : tes_pkg

// ==== src/tes_encoder.sv ====
/*
 Transmit encoder: data FIFO, frame sequencer, envelope and symbol output.
 Assumes synchronous inputs on mclk and symbol lengths from outside.
*/
`timescale 1ns/100ps
// How it works
// R01 - Frame step: each byte framed separately
// R02 - Frame step: internal retrigger before next byte
// R03 - Otherwise stream all bytes, frame once
// R04 - Miller enable applies modified Miller pulses
// R05 - Pulse select picks pulse position
// R06 - Software pairs Miller with pulse start
// R07 - Invert bit inverts data envelope
// R08 - Envelope select shapes pseudo bit stream
// R09 - Envelope codes direct, Manchester, BPSK, RZ
// R10 - Symbol two subcarrier 424 or 848
// R11 - Symbol two bit rate 26..848 kHz
// R12 - Symbol zero/one subcarrier 424 or 848
// R13 - Symbol zero/one bit rate same coding
// R14 - Symbol zero pattern from two bytes
// R15 - Symbol one pattern from two bytes
// R16 - Lower address holds upper pattern byte
// R17 - Only length-setting pattern bits are sent; symbol two always goes out whole
// R18 - Settings sampled at transmission start

// ****************************************
// Data FIFO
// ****************************************
module tes_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Fill side
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady
);
   // Pointers wrap naturally, so D must be a power of two
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] rdPtr;
      logic [AW-1:0] wrPtr;
      logic [AW:0] count;
   } tes_fifo_st_t;
   tes_fifo_st_t st_ff;
   tes_fifo_st_t nxt_st;
   logic push;
   logic pop;

   assign inReady = st_ff.count != (AW+1)'(D);
   assign outValid = st_ff.count != '0;
   assign outData = st_ff.mem[st_ff.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wrPtr] = inData;
         nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
      end
      if (pop) begin
         nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
      end
      nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : tes_fifo

// ****************************************
// Encoder top
// ****************************************
module tes_encoder import tes_pkg::*; #(
   parameter logic [11:0] BIT_CYCLES = 12'h3af,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic [7:0] regWrData,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // Symbol lengths held elsewhere
   input wire logic [3:0] symZeroLength,
   input wire logic [3:0] symOneLength,
   // Transmit data bytes
   input wire logic dataValid,
   input wire logic [7:0] dataByte,
   output logic dataReady,
   // Trigger and transmitter
   input wire logic txStart,
   output logic txEnvelope,
   output logic txActive
);
   tes_st_t s_ff;
   tes_st_t nxt_s;
   logic fifoValid;
   logic fifoPop;
   logic [7:0] fifoData;
   logic [11:0] bitLen;
   logic [11:0] scHalf;
   logic [11:0] q1;
   logic [11:0] q2;
   logic [11:0] q3;
   logic [11:0] pStart;
   logic [1:0] pulsePos;
   logic bitDone;
   logic curBit;
   logic h1;
   logic pulseOn;
   logic envData;
   logic symBit;

   function automatic logic [11:0] rate_cycles(input logic [2:0] code);
      case (code)
         RATE_26K: rate_cycles = CYC_26K;
         RATE_53K: rate_cycles = CYC_53K;
         RATE_106K: rate_cycles = CYC_106K;
         RATE_212K: rate_cycles = CYC_212K;
         RATE_424K: rate_cycles = CYC_424K;
         RATE_848K: rate_cycles = CYC_848K;
         // Reserved codes fall back to a safe middle rate
         default: rate_cycles = CYC_106K;
      endcase
   endfunction : rate_cycles

   function automatic logic [11:0] sc_half(input logic sel);
      sc_half = sel ? CYC_SC848 : CYC_SC424;
   endfunction : sc_half

   tes_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .inValid(dataValid),
      .inData(dataByte),
      .inReady(dataReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(fifoPop)
   );

   assign regRdData = s_ff.rdData;
   assign txEnvelope = s_ff.env;
   assign txActive = s_ff.active;

   // ****************************************
   // Bit timing and envelope shaping
   // ****************************************
   always_comb begin
      unique case (s_ff.state)
         ST_DATA: begin
            bitLen = BIT_CYCLES;
            scHalf = sc_half(s_ff.cfg.symLoPairSubcarrierSel);
         end
         ST_GAP: begin
            bitLen = rate_cycles(s_ff.cfg.symHiPairBitrateSel); // R11
            scHalf = sc_half(s_ff.cfg.symHiPairSubcarrierSel); // R10
         end
         default: begin
            bitLen = rate_cycles(s_ff.cfg.symLoPairBitrateSel); // R13
            scHalf = sc_half(s_ff.cfg.symLoPairSubcarrierSel); // R12
         end
      endcase
      bitDone = s_ff.cyc == bitLen - 12'h001;
      q1 = bitLen >> 2;
      q2 = bitLen >> 1;
      q3 = q1 + q2;
      h1 = s_ff.cyc < q2;
      curBit = s_ff.shift[0];
      // Sym2 goes out whole: its length setting is not held here
      if (s_ff.state == ST_SOF) begin
         symBit = s_ff.cfg.sym0[s_ff.bitIdx]; // R17
      end else if (s_ff.state == ST_EOF) begin
         symBit = s_ff.cfg.sym1[s_ff.bitIdx]; // R17
      end else begin
         symBit = s_ff.cfg.sym2[s_ff.bitIdx[2:0]];
      end
      // Miller: one pulses mid bit, zero at start unless after a one
      if (s_ff.cfg.dataMillerEnable) begin
         pulsePos = curBit ? PULSE_HALF : PULSE_START; // R04 R06
      end else begin
         pulsePos = s_ff.cfg.dataPulseSelect; // R05
      end
      unique case (pulsePos)
         PULSE_HALF: pStart = q2;
         PULSE_Q3: pStart = q3;
         default: pStart = '0;
      endcase
      pulseOn = s_ff.cyc >= pStart && s_ff.cyc < pStart + q1;
      if (s_ff.cfg.dataMillerEnable) begin
         pulseOn = pulseOn && (curBit || !s_ff.prevBit); // R04
      end else begin
         pulseOn = pulseOn && curBit;
      end
      case (s_ff.cfg.dataEnvelopeSelect) // R08
         ENV_DIRECT: envData = curBit; // R09
         ENV_MANCH: envData = h1 ? curBit : !curBit; // R09
         ENV_MANCH_SC: envData = (h1 ? curBit : !curBit) && s_ff.scPh; // R09
         ENV_BPSK: envData = curBit ^ s_ff.scPh; // R09
         ENV_RZ_LATE: envData = curBit && !h1; // R09
         ENV_RZ_EARLY: envData = curBit && h1; // R09
         default: envData = 1'b0;
      endcase
      // Carrier drops for the length of each pulse
      if (s_ff.cfg.dataPulseSelect != PULSE_NONE) begin
         envData = !pulseOn; // R05
      end
      envData = envData ^ s_ff.cfg.dataEnvelopeInvert; // R07
   end

   // ****************************************
   // Registers and frame sequencer
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      fifoPop = 1'b0;
      if (regWr) begin
         case (regAddr)
            OFS_MOD: nxt_s.regs.modCtrl = regWrData;
            OFS_FREQ: nxt_s.regs.symFreq = regWrData;
            OFS_S0H: nxt_s.regs.symZeroUpperByte = regWrData;
            OFS_S0L: nxt_s.regs.symZeroLowerByte = regWrData;
            OFS_S1H: nxt_s.regs.symOneUpperByte = regWrData;
            OFS_S1L: nxt_s.regs.symOneLowerByte = regWrData;
            OFS_S2: nxt_s.regs.symTwoPatternByte = regWrData;
            default: ;
         endcase
      end
      if (regRd) begin
         case (regAddr)
            OFS_MOD: nxt_s.rdData = s_ff.regs.modCtrl;
            OFS_FREQ: nxt_s.rdData = s_ff.regs.symFreq;
            OFS_S0H: nxt_s.rdData = s_ff.regs.symZeroUpperByte;
            OFS_S0L: nxt_s.rdData = s_ff.regs.symZeroLowerByte;
            OFS_S1H: nxt_s.rdData = s_ff.regs.symOneUpperByte;
            OFS_S1L: nxt_s.rdData = s_ff.regs.symOneLowerByte;
            OFS_S2: nxt_s.rdData = s_ff.regs.symTwoPatternByte;
            default: nxt_s.rdData = 8'h00;
         endcase
      end
      // Subcarrier divider, free running while a frame is out
      if (s_ff.sc >= scHalf - 12'h001) begin
         nxt_s.sc = '0;
         nxt_s.scPh = !s_ff.scPh;
      end else begin
         nxt_s.sc = s_ff.sc + 12'h001;
      end
      nxt_s.cyc = bitDone ? 12'h000 : s_ff.cyc + 12'h001;
      unique case (s_ff.state)
         ST_IDLE: begin
            nxt_s.sc = '0;
            nxt_s.scPh = 1'b0;
            nxt_s.cyc = '0;
            // A trigger with nothing queued is ignored
            if (txStart && fifoValid) begin
               nxt_s.state = ST_SOF;
               nxt_s.active = 1'b1;
               nxt_s.bitIdx = symZeroLength; // R17
               nxt_s.cfg.frameStep = s_ff.regs.modCtrl[MOD_FSTEP]; // R18
               nxt_s.cfg.dataMillerEnable = s_ff.regs.modCtrl[MOD_MILLER];
               nxt_s.cfg.dataPulseSelect =
                  s_ff.regs.modCtrl[MOD_PULSE +: 2];
               nxt_s.cfg.dataEnvelopeInvert = s_ff.regs.modCtrl[MOD_INV];
               nxt_s.cfg.dataEnvelopeSelect =
                  s_ff.regs.modCtrl[MOD_ENV +: 3];
               nxt_s.cfg.symHiPairSubcarrierSel =
                  s_ff.regs.symFreq[FRQ_HI_SC];
               nxt_s.cfg.symHiPairBitrateSel =
                  s_ff.regs.symFreq[FRQ_HI_BR +: 3];
               nxt_s.cfg.symLoPairSubcarrierSel =
                  s_ff.regs.symFreq[FRQ_LO_SC];
               nxt_s.cfg.symLoPairBitrateSel =
                  s_ff.regs.symFreq[FRQ_LO_BR +: 3];
               nxt_s.cfg.sym0 = {s_ff.regs.symZeroUpperByte,
                  s_ff.regs.symZeroLowerByte}; // R14 R16
               nxt_s.cfg.sym1 = {s_ff.regs.symOneUpperByte,
                  s_ff.regs.symOneLowerByte}; // R15 R16
               nxt_s.cfg.sym2 = s_ff.regs.symTwoPatternByte;
               nxt_s.cfg.symZeroLen = symZeroLength;
               nxt_s.cfg.symOneLen = symOneLength;
            end
         end
         ST_SOF: begin
            if (bitDone) begin
               if (s_ff.bitIdx == 4'h0) begin
                  fifoPop = 1'b1;
                  nxt_s.state = ST_DATA;
                  nxt_s.shift = fifoData;
                  nxt_s.bitIdx = BYTE_TOP;
                  nxt_s.prevBit = 1'b0;
               end else begin
                  nxt_s.bitIdx = s_ff.bitIdx - 4'h1;
               end
            end
         end
         ST_DATA: begin
            if (bitDone) begin
               nxt_s.prevBit = curBit;
               if (s_ff.bitIdx != 4'h0) begin
                  nxt_s.shift = s_ff.shift >> 1;
                  nxt_s.bitIdx = s_ff.bitIdx - 4'h1;
               end else if (!s_ff.cfg.frameStep && fifoValid) begin
                  fifoPop = 1'b1; // R03
                  nxt_s.shift = fifoData;
                  nxt_s.bitIdx = BYTE_TOP;
               end else begin
                  nxt_s.state = ST_EOF; // R01 R03
                  nxt_s.bitIdx = s_ff.cfg.symOneLen; // R17
               end
            end
         end
         ST_EOF: begin
            if (bitDone && s_ff.bitIdx == 4'h0) begin
               if (s_ff.cfg.frameStep && fifoValid) begin
                  nxt_s.state = ST_GAP; // R02
                  nxt_s.bitIdx = SYM2_TOP;
               end else begin
                  nxt_s.state = ST_IDLE;
                  nxt_s.active = 1'b0;
               end
            end else if (bitDone) begin
               nxt_s.bitIdx = s_ff.bitIdx - 4'h1;
            end
         end
         ST_GAP: begin
            // Internal retrigger once the pause symbol is out
            if (bitDone && s_ff.bitIdx == 4'h0) begin
               nxt_s.state = ST_SOF; // R01 R02
               nxt_s.bitIdx = s_ff.cfg.symZeroLen;
            end else if (bitDone) begin
               nxt_s.bitIdx = s_ff.bitIdx - 4'h1;
            end
         end
         default: begin
            nxt_s.state = ST_IDLE;
            nxt_s.active = 1'b0;
         end
      endcase
      // Symbols key the subcarrier; data uses its shaped envelope
      if (s_ff.state == ST_DATA) begin
         nxt_s.env = envData;
      end else if (s_ff.state == ST_IDLE) begin
         nxt_s.env = 1'b0;
      end else begin
         nxt_s.env = symBit && s_ff.scPh;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_ff <= '0;
         s_ff.state <= ST_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_sym_zero_pat: assert property ($rose(s_ff.active) |-> // R14
      s_ff.cfg.sym0 == $past({s_ff.regs.symZeroUpperByte,
      s_ff.regs.symZeroLowerByte}))
      else $error("symbol zero pattern not assembled");
   a_sym_one_pat: assert property ($rose(s_ff.active) |-> // R15
      s_ff.cfg.sym1[15:8] == $past(s_ff.regs.symOneUpperByte))
      else $error("symbol one upper byte misplaced");
   a_cfg_hold: assert property (s_ff.active && $past(s_ff.active) |-> // R18
      $stable(s_ff.cfg))
      else $error("settings changed inside a transmission");
   a_sof_len: assert property ($rose(s_ff.active) |-> // R17
      s_ff.bitIdx == s_ff.cfg.symZeroLen)
      else $error("start symbol length not taken");
   // Gap spans eight slow symbol bits, so check its exit edge
   a_gap_step: assert property (s_ff.state == ST_GAP && bitDone && // R02
      s_ff.bitIdx == 4'h0 |=> s_ff.state == ST_SOF && s_ff.cfg.frameStep)
      else $error("gap without frame step or no retrigger");
   a_stream_on: assert property (s_ff.state == ST_DATA && bitDone && // R03
      s_ff.bitIdx == 4'h0 && !s_ff.cfg.frameStep && fifoValid
      |=> s_ff.state == ST_DATA && s_ff.bitIdx == BYTE_TOP)
      else $error("stream broke with data queued");
   a_step_eof: assert property (s_ff.state == ST_DATA && bitDone && // R01
      s_ff.bitIdx == 4'h0 && s_ff.cfg.frameStep |=> s_ff.state == ST_EOF)
      else $error("byte not closed in frame step");
   a_env_direct: assert property (s_ff.state == ST_DATA && // R07
      s_ff.cfg.dataEnvelopeSelect == ENV_DIRECT &&
      s_ff.cfg.dataPulseSelect == PULSE_NONE |=>
      txEnvelope == ($past(s_ff.shift[0]) ^ s_ff.cfg.dataEnvelopeInvert))
      else $error("direct envelope or inversion wrong");
   a_rz_late: assert property (s_ff.state == ST_DATA && h1 && // R09
      s_ff.cfg.dataEnvelopeSelect == ENV_RZ_LATE &&
      s_ff.cfg.dataPulseSelect == PULSE_NONE |=>
      txEnvelope == s_ff.cfg.dataEnvelopeInvert)
      else $error("late RZ pulse in first half");
   a_miller_one: assert property (s_ff.state == ST_DATA && // R04
      s_ff.cfg.dataMillerEnable && s_ff.shift[0] && s_ff.cyc == 12'h000 &&
      s_ff.cfg.dataPulseSelect != PULSE_NONE |=>
      txEnvelope == !s_ff.cfg.dataEnvelopeInvert)
      else $error("Miller one pulsed at bit start");
   a_sym_rate: assert property (s_ff.state == ST_SOF |-> // R13
      s_ff.cyc < rate_cycles(s_ff.cfg.symLoPairBitrateSel))
      else $error("symbol bit overran its rate");
   a_sc_rate: assert property (s_ff.active |-> s_ff.sc < CYC_SC424) // R12
      else $error("subcarrier divider overran");

   c_frame_step: cover property (s_ff.state == ST_GAP ##1
      s_ff.state == ST_SOF);
   c_stream: cover property (fifoPop && s_ff.state == ST_DATA);
   c_miller: cover property (s_ff.state == ST_DATA &&
      s_ff.cfg.dataMillerEnable);
   c_bpsk: cover property (s_ff.state == ST_DATA &&
      s_ff.cfg.dataEnvelopeSelect == ENV_BPSK);
endmodule : tes_encoder

// ==== sim/tes_card_model.sv ====
/*
 Card-side model: counts active and envelope-high cycles of each frame.
 Assumes the encoder's envelope lags its active flag by one mclk cycle.
*/
`timescale 1ns/100ps
module tes_card_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Field from the reader
   input wire logic txEnvelope,
   input wire logic txActive,
   // Per-frame counts
   output logic [15:0] actCyc,
   output logic [15:0] highCyc
);
   logic actDly;
   // Counts restart at each frame; delayed window catches lagging envelope
   always_ff @(posedge mclk) begin
      actDly <= srst ? 1'b0 : txActive;
      if (txActive && !actDly) begin
         actCyc <= 16'h0001;
         highCyc <= 16'h0000;
      end else begin
         actCyc <= actCyc + {15'h0000, txActive};
         highCyc <= highCyc + {15'h0000, actDly & txEnvelope};
      end
   end
endmodule : tes_card_model

// ==== sim/testbench.sv ====
/*
 Self-checking bench for the transmit envelope and symbol encoder.
 Assumes tes_pkg, tes_encoder and the card model share mclk.
*/
`timescale 1ns/100ps
module testbench import tes_pkg::*;;
   // ****************************************
   // Signals
   // ****************************************
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic dataValid = 1'b0;
   logic txStart = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] dataByte = 8'h00;
   logic [3:0] symZeroLength = 4'h0;
   logic [3:0] symOneLength = 4'h0;
   logic [7:0] regRdData;
   logic dataReady, txEnvelope, txActive;
   logic [15:0] actCyc, highCyc;
   int errCount = 0;
   int numChecks = 0;
   // Short data bit keeps the run well under the cycle budget
   localparam logic [11:0] BITC = 12'h010;
   localparam logic [15:0] DB = 16'(8 * BITC);
   localparam logic [15:0] BASE = 16'(2 * CYC_848K) + DB;
   always #5 mclk = ~mclk;
   tes_encoder #(.BIT_CYCLES(BITC), .FIFO_DEPTH(16)) uut (.mclk(mclk),
      .srst(srst), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
      .regRd(regRd), .regRdData(regRdData), .symZeroLength(symZeroLength),
      .symOneLength(symOneLength), .dataValid(dataValid),
      .dataByte(dataByte), .dataReady(dataReady), .txStart(txStart),
      .txEnvelope(txEnvelope), .txActive(txActive));
   tes_card_model card (.mclk(mclk), .srst(srst), .txEnvelope(txEnvelope),
      .txActive(txActive), .actCyc(actCyc), .highCyc(highCyc));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, exp);
      numChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, d);
      @(negedge mclk);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(negedge mclk);
      regWr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regRd = 1'b1;
      @(negedge mclk);
      regRd = 1'b0;
      d = regRdData;
   endtask : rd
   task automatic push(input logic [7:0] b);
      @(negedge mclk);
      dataValid = 1'b1;
      dataByte = b;
      @(negedge mclk);
      dataValid = 1'b0;
   endtask : push
   // Start, optionally reprogram mid-frame, wait for the frame to end
   task automatic send(input bit mid);
      int n;
      @(negedge mclk);
      txStart = 1'b1;
      @(negedge mclk);
      txStart = 1'b0;
      check("txActive", {15'h0000, txActive}, 16'h0001);
      if (mid) wr(OFS_MOD, 8'h08);
      n = 0;
      while (txActive === 1'b1 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      // A hung frame counts as a mismatch
      if (n == 40000) errCount++;
      @(negedge mclk);
   endtask : send
   task automatic frame(input logic [7:0] m, b, input logic [15:0] act, hi);
      wr(OFS_MOD, m);
      push(b);
      send(1'b0);
      check("active cycles", actCyc, act);
      if (hi !== 16'hffff) check("high cycles", highCyc, hi);
   endtask : frame
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         rd(OFS_MOD + 8'(i), d);
         check("reset value", {8'h00, d}, {8'h00, REG_RST});
         wr(OFS_MOD + 8'(i), 8'h5a ^ 8'(i));
         rd(OFS_MOD + 8'(i), d);
         check("readback", {8'h00, d},
            (i < 7) ? 16'(8'h5a ^ 8'(i)) : 16'h0000);
         wr(OFS_MOD + 8'(i), 8'h00);
      end
      wr(OFS_FREQ, 8'h77);
      $display("test regs done");
   endtask : t_regs
   task automatic t_pattern();
      // Fast subcarrier: one keyed half falls inside one symbol bit
      wr(OFS_FREQ, 8'h7f);
      wr(OFS_S0H, 8'hff);
      frame(8'h00, 8'h00, BASE, 16'h0000);
      wr(OFS_S0L, 8'h01);
      frame(8'h00, 8'h00, BASE, 16'(CYC_SC848));
      wr(OFS_S0L, 8'h00);
      symZeroLength = 4'hf;
      symOneLength = 4'h3;
      frame(8'h00, 8'h00, BASE + 16'(18 * CYC_848K), 16'hffff);
      check("upper byte keyed", {15'h0000, highCyc != 0}, 16'h0001);
      symZeroLength = 4'h0;
      symOneLength = 4'h0;
      wr(OFS_S0H, 8'h00);
      wr(OFS_FREQ, 8'h77);
      $display("test pattern done");
   endtask : t_pattern
   task automatic t_modes();
      // BPSK ones stay high only after the subcarrier phase drops
      logic [15:0] env [8] = '{DB, DB / 2, 16'hffff,
         DB + 16'(CYC_848K) - 16'(2 * CYC_SC424), DB / 2,
         DB / 2, 16'h0000, 16'h0000};
      for (int e = 0; e < 8; e++) frame(8'(e), 8'hff, BASE, env[e]);
      for (int p = 1; p < 4; p++)
         frame({2'b00, 2'(p), 4'h0}, 8'hff, BASE, DB * 3 / 4);
      frame(8'h50, 8'hff, BASE, DB * 3 / 4);
      frame(8'h08, 8'h00, BASE, DB);
      $display("test modes done");
   endtask : t_modes
   task automatic t_rates();
      logic [15:0] cyc [6] = '{16'(CYC_26K), 16'(CYC_53K), 16'(CYC_106K),
         16'(CYC_212K), 16'(CYC_424K), 16'(CYC_848K)};
      for (int c = 0; c < 6; c++) begin
         wr(OFS_FREQ, {5'h0e, 3'(c + 2)});
         frame(8'h00, 8'h00, 2 * cyc[c] + DB, 16'h0000);
      end
      for (int c = 2; c < 6; c += 3) begin
         wr(OFS_FREQ, {1'b0, 3'(c + 2), 4'h7});
         wr(OFS_MOD, 8'h80);
         push(8'h00);
         push(8'h00);
         send(1'b0);
         check("step frames", actCyc, 2 * BASE + 8 * cyc[c]);
      end
      wr(OFS_FREQ, 8'h77);
      $display("test rates done");
   endtask : t_rates
   task automatic t_stream();
      wr(OFS_MOD, 8'h00);
      for (int i = 0; i < 16; i++) push(8'hff);
      check("full", {15'h0000, dataReady}, 16'h0000);
      send(1'b0);
      check("stream cycles", actCyc, BASE + 15 * DB);
      check("drained", {15'h0000, dataReady}, 16'h0001);
      push(8'hff);
      send(1'b1);
      check("snapshot", highCyc, DB);
      $display("test stream done");
   endtask : t_stream
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      t_regs();
      t_pattern();
      t_modes();
      t_rates();
      t_stream();
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge mclk);
      errCount++;
      report_and_stop();
   end
endmodule : testbench
